/* edge_sync.sv */
// two-flop synchroniser with selectable edge detection for the count pin
module edge_sync (
    input wire logic clk,
    input wire logic rstn,
    input wire logic pin,
    input wire logic falling,
    output logic edge_seen
);
    logic meta;
    logic sync;
    logic last;
    wire rise = sync & ~last;
    wire fall = ~sync & last;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta <= 1'b0;
            sync <= 1'b0;
            last <= 1'b0;
        end else begin
            meta <= pin;
            sync <= meta;
            last <= sync;
        end
    end
    assign edge_seen = falling ? fall : rise;
endmodule : edge_sync

/* pulse_src.sv */
// partner model: pulse source on the external count pin
module pulse_src (
    input wire logic clk,
    output logic pin
);
    timeunit 1ns;
    timeprecision 1ps;
    initial pin = 1'b0;
    // idle low between bursts; hp picks prompt or slow edges
    task automatic send(input int n, input int hp);
        repeat (n) begin
            repeat (hp) @(posedge clk);
            pin <= 1'b1;
            repeat (hp) @(posedge clk);
            pin <= 1'b0;
        end
    endtask : send
endmodule : pulse_src

/* tb_top.sv */
// self-checking bench for the timer/counter with shared prescaler
module tb_top
    import timer0_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic sleep = 1'b0;
    logic rc_mode = 1'b0;
    logic watchdog_tick = 1'b0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, external_count_pin, watchdog_timer_tick, clock_output_pin, irq, overflow_irq;
    int failures = 0;
    int total_checks = 0;
    int watchdog_seen = 0;
    int model_q[$];
    always #2.5 clk = ~clk;
    always @(posedge clk) if (watchdog_timer_tick === 1'b1) watchdog_seen++;
    timer0_counter_prescaler i_dut (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .external_count_pin, .sleep, .rc_mode, .watchdog_tick, .watchdog_timer_tick,
        .clock_output_pin, .irq, .overflow_irq);
    pulse_src i_src (.clk, .pin(external_count_pin));
    task automatic test_done();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // returns at the edge where pready was seen, request already released
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            failures++;
            $display("CHECK FAILED at %0t: no ready", $time);
            test_done();
        end
        rd = {prdata[31:1], prdata[0]};
        if (!w) check(pslverr, a > mask_offset);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        logic [7:0] n;
        int r;
        void'($urandom(98204));
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        rc_mode <= 1'b1;
        apb(0, option_offset, 0);
        check(rd, 32'(option_reset));
        apb(0, control_offset, 0);
        check(rd, 32'(control_reset));
        apb(0, 8'h14, 0);
        check(rd, 32'h0000_0000);
        apb(1, option_offset, 32'h0000_0008);
        repeat (8) begin
            watchdog_tick <= 1'b1;
            @(posedge clk);
            watchdog_tick <= 1'b0;
            @(posedge clk);
        end
        repeat (4) @(posedge clk);
        check(watchdog_seen, 4);
        $display("reset and watchdog test done");
        n = 8'($urandom);
        model_q.push_back(int'(n));
        model_q.push_back((int'(n) + 2) % 256);
        apb(1, count_offset, 32'(n));
        apb(0, count_offset, 0);
        check(rd, 32'(model_q.pop_front()));
        apb(0, count_offset, 0);
        check(rd, 32'(model_q.pop_front()));
        apb(1, control_offset, 0);
        apb(1, count_offset, 32'h0000_00FD);
        repeat (6) @(posedge clk);
        apb(0, control_offset, 0);
        check(rd[overflow_flag_bit], 1'b1);
        check(overflow_irq, 1'b0);
        apb(1, mask_offset, 32'h0000_0001);
        apb(1, control_offset, 32'h0000_0024);
        repeat (2) @(negedge clk);
        check(overflow_irq, 1'b1);
        check(irq, 1'b1);
        apb(0, status_offset, 0);
        check(rd[evt_overflow_bit], 1'b1);
        apb(0, status_offset, 0);
        check(rd[evt_overflow_bit], 1'b0);
        repeat (2) @(negedge clk);
        check(irq, 1'b0);
        apb(1, control_offset, 32'h0000_0020);
        repeat (2) @(negedge clk);
        check(overflow_irq, 1'b0);
        $display("timer and overflow test done");
        for (int k = 0; k < 8; k++) begin
            apb(1, option_offset, 32'(32 + 16 * (k % 2) + k));
            repeat (4) @(posedge clk);
            apb(1, count_offset, 0);
            r = (2 << k) * 2 + int'($urandom % (2 << k));
            model_q.push_back(r / (2 << k));
            i_src.send(r, 2 + 3 * (k % 2));
            repeat (8) @(posedge clk);
            apb(0, count_offset, 0);
            check(rd, 32'(model_q.pop_front()));
        end
        apb(0, status_offset, 0);
        check(rd[evt_edge_bit], 1'b1);
        $display("counter and prescaler test done");
        apb(1, option_offset, 0);
        sleep <= 1'b1;
        rc_mode <= 1'b0;
        apb(0, count_offset, 0);
        n = rd[7:0];
        repeat (20) @(posedge clk);
        apb(0, count_offset, 0);
        check(rd, 32'(n));
        $display("sleep test done");
        test_done();
    end
endmodule : tb_top

/* timer0_counter_prescaler.sv */
// timer/counter with shared watchdog prescaler, apb register access
module timer0_counter_prescaler
    import timer0_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic external_count_pin,
    input wire logic sleep,
    input wire logic rc_mode,
    input wire logic watchdog_tick,
    output logic watchdog_timer_tick,
    output logic clock_output_pin,
    output logic irq,
    output logic overflow_irq
);
    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0] count_register;
    logic [7:0] option;
    logic [7:0] control;
    logic [7:0] prescaler;
    logic [1:0] hold;
    logic [1:0] status;
    logic [1:0] mask;
    logic [1:0] div_cnt;

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    wire access = psel & penable;
    wire wr = access & pwrite;
    wire rd = access & ~pwrite;
    wire hit_count = (paddr == count_offset);
    wire hit_option = (paddr == option_offset);
    wire hit_control = (paddr == control_offset);
    wire hit_status = (paddr == status_offset);
    wire hit_mask = (paddr == mask_offset);
    wire mapped = hit_count | hit_option | hit_control | hit_status | hit_mask;
    wire count_write = wr & hit_count;

    // ----------------------------------------
    // count source selection
    // ----------------------------------------
    wire clock_source_select = option[clock_source_select_bit];
    wire source_edge_select = option[source_edge_select_bit];
    wire prescaler_assign = option[prescaler_assign_bit];
    wire [2:0] ps_select = option[ps_lsb +: 3];
    logic pin_edge;

    edge_sync u_sync (
        .clk(clk),
        .rstn(rstn),
        .pin(external_count_pin),
        .falling(source_edge_select),
        .edge_seen(pin_edge)
    );

    // timer mode ticks every cycle, counter mode on a qualified pin edge
    wire src_tick = clock_source_select ? pin_edge : 1'b1;
    // watchdog takes the prescaler when assigned away from the timer
    wire ps_in = prescaler_assign ? watchdog_tick : src_tick;
    wire [8:0] ps_sum = {1'b0, prescaler} + 9'h001;
    // terminal for ratio 1:2^(n+1): the low n+1 bits all ones
    function automatic logic ps_done(input logic [7:0] cnt, input logic [2:0] sel);
        logic [7:0] m;
        m = 8'hFF >> (3'h7 - sel);
        ps_done = ((cnt & m) == m);
    endfunction : ps_done
    wire ps_out = ps_in & ps_done(prescaler, ps_select);
    wire timer_tick = prescaler_assign ? src_tick : ps_out;
    // sleep freezes the count, so no overflow can occur while asleep
    wire inc = timer_tick & (hold == 2'h0) & ~sleep;
    wire wrap = inc & (count_register == 8'hFF);

    // ----------------------------------------
    // next values
    // ----------------------------------------
    wire [7:0] next_count = count_write ? pwdata[7:0] :
                            inc ? count_register + 8'h01 : count_register;
    wire [1:0] next_hold = count_write ? write_hold_cycles :
                           (hold != 2'h0) ? hold - 2'h1 : 2'h0;
    // prescaler is frozen in sleep only when it serves the timer
    wire ps_step = ps_in & ~(sleep & ~prescaler_assign);
    wire ps_clear = count_write & ~prescaler_assign;
    wire [7:0] next_prescaler = ps_clear ? 8'h00 :
                                ps_step ? (ps_out ? 8'h00 : ps_sum[7:0]) : prescaler;
    // overflow set wins over a software clear in the same cycle
    wire ctl_wr = wr & hit_control;
    wire [7:0] ctl_base = ctl_wr ? pwdata[7:0] : control;
    wire [7:0] next_control = ctl_base | ({7'h00, wrap} << overflow_flag_bit);
    wire [1:0] events = {pin_edge, wrap};
    // only the bits handed out at setup are cleared, so an event in the setup cycle survives
    wire [1:0] status_base = (rd & hit_status) ? (status & ~prdata[1:0]) : status;
    wire [1:0] next_status = status_base | events;
    wire next_overflow_irq = next_control[overflow_flag_bit]
                             & next_control[overflow_irq_enable_bit];
    wire next_irq = |(next_status & mask);

    // prescaler never appears in the read mux
    wire [7:0] rd_mux = hit_count ? count_register :
                        hit_option ? option :
                        hit_control ? control :
                        hit_status ? {6'h00, status} :
                        hit_mask ? {6'h00, mask} : 8'h00;

    // ----------------------------------------
    // state
    // ----------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count_register <= 8'h00;
            prescaler <= 8'h00;
            hold <= 2'h0;
            control <= control_reset;
            status <= 2'h0;
        end else begin
            count_register <= next_count;
            prescaler <= next_prescaler;
            hold <= next_hold;
            control <= next_control;
            status <= next_status;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            option <= option_reset;
            mask <= 2'h0;
        end else begin
            if (wr & hit_option) begin
                option <= pwdata[7:0];
            end
            if (wr & hit_mask) begin
                mask <= pwdata[1:0];
            end
        end
    end

    // ----------------------------------------
    // bus answer: zero wait states
    // ----------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata <= (psel & ~penable & ~pwrite) ? {24'h00_0000, rd_mux} : prdata;
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
        end
    end

    // ----------------------------------------
    // outputs, clock divider
    // ----------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            div_cnt <= 2'h0;
            clock_output_pin <= 1'b0;
            irq <= 1'b0;
            overflow_irq <= 1'b0;
            watchdog_timer_tick <= 1'b0;
        end else begin
            div_cnt <= div_cnt + 2'h1;
            // clk stands in for the oscillator here; output has period of four
            clock_output_pin <= rc_mode & (div_cnt < 2'(clk_div / 2));
            irq <= next_irq;
            overflow_irq <= next_overflow_irq;
            watchdog_timer_tick <= prescaler_assign ? ps_out : 1'b0;
        end
    end
endmodule : timer0_counter_prescaler

/* timer0_pkg.sv */
// constants and register layout for the timer/counter with shared prescaler
// Contract
// - count register is eight bits; wrap from ff to 00 sets overflow flag
// - timer mode when clock source select (option bit 5) is zero
// - timer mode without prescaler increments once every instruction cycle
// - after a count register write, increments are held off two cycles
// - clock source select one counts edges of the external count pin
// - source edge select (option bit 4): zero rising, one falling edge
// - prescaler shared; assign bit (option bit 3) zero gives it to timer
// - prescaler divides count clock by 2 up to 256, power of two
// - software can neither read nor write the prescaler count
// - overflow interrupt suppressed while enable bit (control bit 5) is zero; irq still rises on overflow when mask bit 0 is set
// - timer stops during sleep, so overflow never wakes the core
// - in rc oscillator mode clock output pin carries oscillator over four
// - a count register write also clears the prescaler if assigned to timer
package timer0_pkg;
    // ----------------------------------------
    // apb register offsets
    // ----------------------------------------
    localparam logic [7:0] count_offset = 8'h00;
    localparam logic [7:0] option_offset = 8'h04;
    localparam logic [7:0] control_offset = 8'h08;
    localparam logic [7:0] status_offset = 8'h0C;
    localparam logic [7:0] mask_offset = 8'h10;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int ps_lsb = 0;
    localparam int prescaler_assign_bit = 3;
    localparam int source_edge_select_bit = 4;
    localparam int clock_source_select_bit = 5;
    localparam int overflow_flag_bit = 2;
    localparam int overflow_irq_enable_bit = 5;
    localparam int evt_overflow_bit = 0;
    localparam int evt_edge_bit = 1;
    // ----------------------------------------
    // reset values and timing
    // ----------------------------------------
    localparam logic [7:0] option_reset = 8'hFF;
    localparam logic [7:0] control_reset = 8'h00;
    localparam logic [1:0] write_hold_cycles = 2'h2;
    localparam int clk_div = 4;
endpackage : timer0_pkg

/* timer0_props.sv */
// checker for bus answers, sticky interrupt outputs and the clock output pin
module timer0_props
    import timer0_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rc_mode,
    input wire logic clock_output_pin,
    input wire logic irq,
    input wire logic overflow_irq
);
    logic wr_ctl;
    logic touch_st;
    // the outputs are registered, so the access edge and the one after are excused
    assign wr_ctl = psel && pwrite && paddr == control_offset;
    assign touch_st = psel && (paddr == status_offset || pwrite && paddr == mask_offset);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    a_ready_setup: assert property (psel && !penable |=> pready) else $error("no ready after setup");
    a_ready_idle: assert property (!psel |=> !pready) else $error("ready without setup");
    a_err_unmapped: assert property (psel && !penable && paddr > mask_offset |=> pslverr)
        else $error("unmapped not refused");
    a_rdata_byte: assert property (pready && !pwrite |-> prdata[31:8] == 24'h00_0000)
        else $error("read data above bit 7");
    a_flag_sticky: assert property (overflow_irq && !wr_ctl && !$past(wr_ctl) |=> overflow_irq)
        else $error("flag dropped by itself");
    a_irq_sticky: assert property (irq && !touch_st && !$past(touch_st) |=> irq) else $error("irq dropped");
    a_clkout_off: assert property (!rc_mode ##1 !rc_mode |-> !clock_output_pin)
        else $error("clock out without rc mode");
    a_clkout_period: assert property (rc_mode && $rose(clock_output_pin) ##1 rc_mode [*4] |->
        $rose(clock_output_pin)) else $error("clock out not divided by four");
endmodule : timer0_props

bind timer0_counter_prescaler timer0_props i_props (.clk, .rstn, .psel, .penable, .pwrite, .paddr,
    .prdata, .pready, .pslverr, .rc_mode, .clock_output_pin, .irq, .overflow_irq);
